// ===== core/qsfd_pkg.sv
// Purpose: Shared constants for the quad switch fault diagnosis block
// Assumes: Four channels, eight-bit serial frames, MSB first
// Notes: Two-bit codes use H = 1, L = 0
package qsfd_pkg;
   localparam int QSFD_CH = 4;
   localparam int QSFD_FRAME_W = 8;
   // Per channel diagnosis codes
   localparam logic [1:0] QSFD_CODE_OK = 2'h3;
   localparam logic [1:0] QSFD_CODE_OVERLOAD = 2'h2;
   localparam logic [1:0] QSFD_CODE_OPEN = 2'h1;
   localparam logic [1:0] QSFD_CODE_SHORT_GND = 2'h0;
   // Command nibbles
   localparam logic [3:0] QSFD_CMD_DIAG = 4'h0;
   localparam logic [3:0] QSFD_CMD_READBACK = 4'hc;
   localparam logic [3:0] QSFD_CMD_ECHO = 4'ha;
   localparam logic [3:0] QSFD_CMD_OR = 4'h3;
   localparam logic [3:0] QSFD_CMD_AND = 4'hf;
   // Reset values
   localparam logic [7:0] QSFD_FRAME_RST = 8'h00;
   localparam logic [3:0] QSFD_DATA_RST = 4'h0;
   localparam logic QSFD_OR_MODE_RST = 1'b1;
   // Frame layout of the command byte
   localparam int QSFD_CMD_MSB = 7;
   localparam int QSFD_CMD_LSB = 4;
   typedef enum logic [1:0] {QSFD_M_FULL, QSFD_M_READBACK, QSFD_M_ECHO} qsfd_mode_t;
endpackage

// ===== core/qsfd_core.sv
// Purpose: Fault latching, fault flag and serial diagnosis shift-out of a quad switch
// Assumes: Serial pins, reset pin and fault detectors are asynchronous to ref_clk;
//          SCLK is slow enough to be oversampled after a two-flop synchroniser
// Notes: Pins are sampled, so SO changes a few ref_clk cycles after each SCLK rising edge, or after each SI change in an echo frame
`timescale 1ns/1ps
module qsfd_core
   import qsfd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic si_pin,
   input wire logic reset_pin_n,
   input wire logic [3:0] par_in_pin,
   input wire logic [3:0] det_overload,
   input wire logic [3:0] det_short_to_supply,
   input wire logic [3:0] det_overtemp,
   input wire logic [3:0] det_open_load,
   input wire logic [3:0] det_short_gnd,
   output logic so_out,
   output logic so_oe_n,
   output logic fault_out,
   output logic fault_oe_n,
   output logic [3:0] out_data,
   output logic or_mode
);

   ////////////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers; the first stage feeds only the second
   // Packed with no filler bits, so every stage bit belongs to a pin
   logic [19:0] sync1_reg;
   logic [19:0] sync2_reg;
   logic cs_d_reg;
   logic sclk_d_reg;
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_reg <= {2'h3, 18'h00000};
         sync2_reg <= {2'h3, 18'h00000};
         cs_d_reg <= 1'b1;
         sclk_d_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= {cs_n_pin, reset_pin_n, sclk_pin, si_pin, par_in_pin,
                       det_overload | det_short_to_supply | det_overtemp,
                       det_open_load, det_short_gnd};
         sync2_reg <= sync1_reg;
         cs_d_reg <= sync2_reg[19];
         sclk_d_reg <= sync2_reg[17];
      end
   end

   // Named views of the synchronised inputs
   wire cs_n_s = sync2_reg[19];
   wire rstpin_n_s = sync2_reg[18];
   wire sclk_s = sync2_reg[17];
   wire si_s = sync2_reg[16];
   wire [3:0] par_in_s = sync2_reg[15:12];
   wire [3:0] limit_s = sync2_reg[11:8];
   wire [3:0] open_s = sync2_reg[7:4];
   wire [3:0] sgnd_s = sync2_reg[3:0];
   wire cs_fall = cs_d_reg & ~cs_n_s;
   wire cs_rise = ~cs_d_reg & cs_n_s;
   wire sclk_rise = ~sclk_d_reg & sclk_s & ~cs_n_s;
   wire sclk_fall = sclk_d_reg & ~sclk_s & ~cs_n_s;

   ////////////////////////////////////////////////////////////////////////////////
   // Per channel fault coding; short to ground outranks open load, so never ambiguous
   logic [7:0] code_reg;
   logic [7:0] code_next;
   logic [3:0] fault_now;
   always_comb
   begin
      code_next = code_reg;
      for (int ch = 0; ch < QSFD_CH; ch++)
      begin
         if (cs_rise)
            code_next[2*ch +: 2] = QSFD_CODE_OK;
         if (sgnd_s[ch])
            code_next[2*ch +: 2] = QSFD_CODE_SHORT_GND;
         else if (open_s[ch])
            code_next[2*ch +: 2] = QSFD_CODE_OPEN;
         else if (limit_s[ch])
            code_next[2*ch +: 2] = QSFD_CODE_OVERLOAD;
      end
   end

   // Latch hold; a fault present in the clearing cycle wins over the clear
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         code_reg <= {4{QSFD_CODE_OK}};
      else
         code_reg <= code_next;
   end

   // One bit per channel, high means the latch reports a fault
   always_comb
   begin
      for (int ch = 0; ch < QSFD_CH; ch++)
         fault_now[ch] = (code_next[2*ch +: 2] != QSFD_CODE_OK);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Open-drain fault flag: pulled low while any latch holds an error
   logic fault_oe_n_reg;
   logic fault_out_reg;
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fault_oe_n_reg <= 1'b1;
         fault_out_reg <= 1'b0;
      end
      else
      begin
         fault_oe_n_reg <= ~(|fault_now);
         fault_out_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frame selection for the next chip select period
   qsfd_mode_t mode_reg;
   qsfd_mode_t mode_next;
   logic [7:0] rx_reg;
   logic [7:0] tx_reg;
   logic [3:0] ok_bits;
   logic [7:0] frame;
   wire [3:0] cmd = rx_reg[QSFD_CMD_MSB:QSFD_CMD_LSB];
   assign ok_bits = ~fault_now;
   assign frame = (mode_reg == QSFD_M_READBACK) ? {par_in_s, ok_bits}
                : code_next;

   // Decode the byte that was shifted in during the ending frame
   always_comb
   begin
      case (cmd)
         QSFD_CMD_READBACK: mode_next = QSFD_M_READBACK;
         QSFD_CMD_ECHO: mode_next = QSFD_M_ECHO;
         default: mode_next = QSFD_M_FULL;
      endcase
   end

   // Mode and output latch update at chip select rise; echo lasts one period unless the byte shifted in during it is again an echo command
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_reg <= QSFD_M_FULL;
         out_data <= QSFD_DATA_RST;
         or_mode <= QSFD_OR_MODE_RST;
      end
      else if (!rstpin_n_s)
      begin
         mode_reg <= QSFD_M_FULL;
         out_data <= QSFD_DATA_RST;
         or_mode <= QSFD_OR_MODE_RST;
      end
      else if (cs_rise)
      begin
         mode_reg <= mode_next;
         if (cmd == QSFD_CMD_OR)
            or_mode <= 1'b1;
         else if (cmd == QSFD_CMD_AND)
            or_mode <= 1'b0;
         if (cmd != QSFD_CMD_DIAG && cmd != QSFD_CMD_READBACK && cmd != QSFD_CMD_ECHO)
            out_data <= rx_reg[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Serial receive on SCLK falling, transmit shift on SCLK rising
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_reg <= QSFD_FRAME_RST;
         tx_reg <= QSFD_FRAME_RST;
         so_out <= 1'b0;
         so_oe_n <= 1'b1;
      end
      else if (!rstpin_n_s)
      begin
         rx_reg <= QSFD_FRAME_RST;
         tx_reg <= QSFD_FRAME_RST;
         so_out <= 1'b0;
         so_oe_n <= 1'b1;
      end
      else
      begin
         so_oe_n <= cs_n_s;
         if (cs_fall)
         begin
            tx_reg <= frame;
            so_out <= (mode_reg == QSFD_M_ECHO) ? si_s : frame[7];
         end
         else if (!cs_n_s && mode_reg == QSFD_M_ECHO)
            so_out <= si_s; // Loopback for the echo frame
         else if (sclk_rise)
         begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            so_out <= tx_reg[6];
         end
         if (sclk_fall)
            rx_reg <= {rx_reg[6:0], si_s};
      end
   end

   assign fault_out = fault_out_reg;
   assign fault_oe_n = fault_oe_n_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   a_flag_follows_fault: assert property (|fault_now |=> !fault_oe_n)
      else $error("fault flag not asserted");
   a_flag_release: assert property (!(|fault_now) |=> fault_oe_n)
      else $error("fault flag not released");
   a_latch_hold: assert property (!cs_rise && !(|sgnd_s) && !(|open_s) && !(|limit_s)
      |=> $stable(code_reg))
      else $error("latched code changed without cause");
   a_cs_clears: assert property (cs_rise && !(|sgnd_s) && !(|open_s) && !(|limit_s)
      |=> code_reg == {4{QSFD_CODE_OK}})
      else $error("chip select rise did not clear latches");
   a_short_code: assert property (sgnd_s[0] |=> code_reg[1:0] == QSFD_CODE_SHORT_GND)
      else $error("short to ground not coded LL");
   a_open_code: assert property (open_s[1] && !sgnd_s[1] |=> code_reg[3:2] == QSFD_CODE_OPEN)
      else $error("open load not coded LH");
   a_limit_code: assert property (limit_s[3] && !open_s[3] && !sgnd_s[3]
      |=> code_reg[7:6] == QSFD_CODE_OVERLOAD)
      else $error("current limit not coded HL");
   a_so_release: assert property (cs_n_s && rstpin_n_s |=> so_oe_n)
      else $error("serial output driven while deselected");
   a_frame_load: assert property (cs_fall && rstpin_n_s |=> tx_reg == $past(frame))
      else $error("frame not loaded at chip select fall");
   a_rx_shift: assert property (sclk_fall && rstpin_n_s |=> rx_reg[0] == $past(si_s))
      else $error("serial input not sampled");
   a_pin_reset: assert property (!rstpin_n_s |=> rx_reg == QSFD_FRAME_RST && out_data == 4'h0)
      else $error("reset pin did not clear");

   c_fault_seen: cover property (!fault_oe_n ##1 cs_rise ##2 fault_oe_n);
   c_readback: cover property (mode_reg == QSFD_M_READBACK && cs_fall);
   c_echo: cover property (mode_reg == QSFD_M_ECHO && sclk_rise);
   c_full_byte: cover property (cs_fall ##[1:1000] cs_rise);

endmodule

// ===== verif/qsfd_host.sv
// Purpose: Host SPI master model driving the serial pins of the quad switch
// Assumes: SCLK idles low; eight bit frames, MSB first
// Notes: Every pin level stands at least eight ref_clk cycles, well above the sync minimum
`timescale 1ns/1ps
module qsfd_host
(
   input wire logic ref_clk,
   input wire logic so_out,
   input wire logic so_oe_n,
   output logic cs_n_pin,
   output logic sclk_pin,
   output logic si_pin
);
   initial
   begin
      cs_n_pin = 1'b1;
      sclk_pin = 1'b0;
      si_pin = 1'b0;
   end
   // Wait on falling edges so pins never move at the sampling edge
   task automatic pause(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // One frame; a released SO reads back inverted so it can never match
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      cs_n_pin = 1'b0;
      pause(8);
      for (int i = 7; i >= 0; i--)
      begin
         si_pin = tx[i];
         pause(8);
         rx[i] = so_oe_n ? ~so_out : so_out;
         sclk_pin = 1'b1;
         pause(8);
         sclk_pin = 1'b0;
         pause(8);
      end
      cs_n_pin = 1'b1;
      pause(12);
   endtask
endmodule

// ===== verif/quad_switch_fault_diagnosis_tb_top.sv
// Purpose: Self-checking bench for fault latching and serial diagnosis
// Assumes: Host model owns the serial pins; bench owns detectors and reset pin
// Notes: Settle wait between repeated commands is shortened; the core has no timer
`timescale 1ns/1ps
module quad_switch_fault_diagnosis_tb_top
   import qsfd_pkg::*;
;
   logic ref_clk = 1'b0;
   logic arst_n, reset_pin_n, so_out, so_oe_n, fault_out, fault_oe_n, or_mode;
   logic cs_n_pin, sclk_pin, si_pin;
   logic [3:0] par_in_pin, out_data, det_ov, det_sup, det_ot, det_open, det_gnd;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   always #2.5 ref_clk = ~ref_clk;
   qsfd_core dut (.ref_clk(ref_clk), .arst_n(arst_n), .cs_n_pin(cs_n_pin),
      .sclk_pin(sclk_pin), .si_pin(si_pin), .reset_pin_n(reset_pin_n),
      .par_in_pin(par_in_pin), .det_overload(det_ov), .det_short_to_supply(det_sup),
      .det_overtemp(det_ot), .det_open_load(det_open), .det_short_gnd(det_gnd),
      .so_out(so_out), .so_oe_n(so_oe_n), .fault_out(fault_out),
      .fault_oe_n(fault_oe_n), .out_data(out_data), .or_mode(or_mode));
   qsfd_host host (.ref_clk(ref_clk), .so_out(so_out), .so_oe_n(so_oe_n),
      .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .si_pin(si_pin));
   ////////////////////////////////////////////////////////////////////////////////
   // Fault kind 0 none, 1..3 current limit, 4 open load, 5 short to ground
   function automatic logic [1:0] code_of(input int k);
      return k == 0 ? QSFD_CODE_OK : k < 4 ? QSFD_CODE_OVERLOAD :
         k == 4 ? QSFD_CODE_OPEN : QSFD_CODE_SHORT_GND;
   endfunction
   task automatic set_det(input int c, input int k);
      det_ov[c] = (k == 1);
      det_sup[c] = (k == 2);
      det_ot[c] = (k == 3);
      det_open[c] = (k == 4);
      det_gnd[c] = (k == 5);
   endtask
   task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Hang guard, sized at several times the expected run
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         errors++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [7:0] rx, exp, cmd;
      logic [3:0] od;
      logic om;
      int ka[4], kb[4];
      void'($urandom(91541));
      arst_n = 1'b0;
      reset_pin_n = 1'b1;
      par_in_pin = 4'($urandom);
      for (int c = 0; c < 4; c++) set_det(c, 0);
      od = 4'h0;
      om = 1'b1;
      host.pause(2);
      arst_n = 1'b1;
      host.pause(6);
      chk("so_oe_n idle", 8'h01, {7'h0, so_oe_n});
      // Random faults per channel, a second fault replacing the first
      for (int it = 0; it < 12; it++)
      begin
         cmd = {(it % 3 == 0) ? 4'h0 : (it % 3 == 1) ? 4'h3 : 4'hf, 4'($urandom)};
         par_in_pin = 4'($urandom);
         for (int c = 0; c < 4; c++)
         begin
            ka[c] = $urandom_range(5);
            kb[c] = it < 2 ? 4 + it : $urandom_range(5);
            exp[2 * c +: 2] = code_of(kb[c] != 0 ? kb[c] : ka[c]);
         end
         foreach (ka[c]) set_det(c, ka[c]);
         host.pause(6);
         foreach (kb[c]) set_det(c, kb[c]);
         host.pause(6);
         foreach (kb[c]) set_det(c, 0);
         host.pause(6);
         chk("fault_oe_n", {7'h0, exp == 8'hff}, {7'h0, fault_oe_n});
         chk("fault_out", 8'h00, {7'h0, fault_out});
         host.xfer(cmd, rx);
         chk("diag frame", exp, rx);
         chk("fault released", 8'h01, {7'h0, fault_oe_n});
         host.pause(40);
         host.xfer(cmd, rx);
         chk("repeat frame", 8'hff, rx);
         od = cmd[7:4] == 4'h0 ? od : cmd[3:0];
         om = cmd[7:4] == 4'h3 ? 1'b1 : cmd[7:4] == 4'hf ? 1'b0 : om;
         chk("mode and data", {3'h0, om, od}, {3'h0, or_mode, out_data});
      end
      $display("test random diagnosis done");
      // Read back of inputs with channel 1 shorted, then its latch after removal
      par_in_pin = 4'($urandom);
      set_det(1, 5);
      host.xfer(8'hc0, rx);
      host.xfer(8'h00, rx);
      chk("readback frame", {par_in_pin, 4'hd}, rx);
      set_det(1, 0);
      host.xfer(8'h00, rx);
      chk("held short", 8'hf3, rx);
      $display("test readback done");
      // Echo loop then reset pin
      cmd = 8'($urandom);
      host.xfer(8'ha0, rx);
      host.xfer(cmd, rx);
      chk("echo frame", cmd, rx);
      host.xfer(8'hf5, rx);
      reset_pin_n = 1'b0;
      host.pause(6);
      chk("reset pin", 8'h10, {3'h0, or_mode, out_data});
      reset_pin_n = 1'b1;
      $display("test echo and reset pin done");
      wrap_up();
   end
endmodule
